// [logic/rwi_pkg.sv]
package rwi_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
  // pll lock wait, microseconds (2 ms)
  localparam int unsigned PLL_LOCK_US   = 2000;
  localparam int unsigned PLL_LOCK_CYC  = PLL_LOCK_US * CLK_PER_US;
  // oscillator start-up wait, cycles
  localparam int unsigned OST_CYC       = 1024;
  localparam int unsigned FAST_CYC      = 8;
  localparam int unsigned CNT_W         = 17;

  localparam int unsigned PC_W          = 21;
  localparam int unsigned SP_W          = 5;
  localparam logic [20:0] VEC_HIGH      = 21'h000008;
  localparam logic [20:0] VEC_LOW       = 21'h000018;

  localparam logic [7:0]  OFS_WDT       = 8'h00;
  localparam logic [7:0]  OFS_RCS       = 8'h04;
  localparam logic [7:0]  OFS_GIE       = 8'h08;
  localparam logic [7:0]  OFS_EVT       = 8'h0c;
  localparam logic [7:0]  OFS_MSK       = 8'h10;
  localparam logic [7:0]  OFS_LAT       = 8'h14;
  localparam logic [7:0]  OFS_DIR       = 8'h18;
  localparam logic [7:0]  OFS_PIN       = 8'h1c;
  localparam logic [7:0]  OFS_STK       = 8'h20;

  localparam int unsigned RCS_PRIORITY_LEVEL_ENABLE      = 7;
  localparam int unsigned RCS_LONG_WRITE_ENABLE      = 6;
  localparam int unsigned RCS_RI        = 4;
  localparam int unsigned RCS_TO        = 3;
  localparam int unsigned RCS_PD        = 2;
  localparam int unsigned RCS_POR       = 1;
  localparam int unsigned RCS_BOR       = 0;
  localparam logic [7:0]  RCS_POR_VAL   = 8'h1c;
  localparam logic [7:0]  RCS_WMASK     = 8'hd3;
  localparam logic [7:0]  WDT_IMPL      = 8'h01;
  localparam logic [7:0]  WDT_RESET     = 8'h00;
  localparam int unsigned GIE_HIGH      = 7;
  localparam int unsigned GIE_LOW       = 6;
  localparam logic [7:0]  GIE_IMPL      = 8'hc0;
  localparam int unsigned EVT_WDT       = 7;
  localparam int unsigned PA_BIT6       = 6;
  localparam logic [7:0]  PA_IMPL       = 8'h7f;
  localparam logic [7:0]  LAT_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET     = 8'h7f;

  typedef enum logic [2:0] {
    OSC_LP    = 3'h0,
    OSC_XT    = 3'h1,
    OSC_HS    = 3'h2,
    OSC_RC    = 3'h3,
    OSC_EC    = 3'h4,
    OSC_EXT_CLOCK_WITH_IO_MODE  = 3'h5,
    OSC_HSPLL = 3'h6,
    OSC_RC_OSC_WITH_IO_MODE  = 3'h7
  } rwi_osc_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE  = 2'h2,
    ST_VECT  = 2'h3
  } rwi_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rwi_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rwi_apb_rsp_type;

endpackage

// [logic/rwi_wake_timer.sv]
`timescale 1ns/1ps
module rwi_wake_timer #(
  parameter int unsigned PLL_CYC = rwi_pkg::PLL_LOCK_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               start,
  input  wire rwi_pkg::rwi_osc_type osc_mode,
  output logic                    done
);
  import rwi_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic             busy_reg;
  logic [CNT_W-1:0] load_cnt;

  always_comb begin
    case (osc_mode)
      OSC_HSPLL: load_cnt = CNT_W'(OST_CYC + PLL_CYC);
      OSC_RC, OSC_RC_OSC_WITH_IO_MODE, OSC_EC, OSC_EXT_CLOCK_WITH_IO_MODE: load_cnt = CNT_W'(FAST_CYC);
      default: load_cnt = CNT_W'(OST_CYC);
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else if (start) begin
      cnt_reg  <= load_cnt;
      busy_reg <= 1'b1;
      done     <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg - CNT_W'(1);
      busy_reg <= (cnt_reg != CNT_W'(1));
      done     <= (cnt_reg == CNT_W'(1));
    end else begin
      done     <= 1'b0;
    end
  end

endmodule

// [logic/rwi_top.sv]
`timescale 1ns/1ps
module rwi_top #(
  parameter int unsigned PLL_CYC = rwi_pkg::PLL_LOCK_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire rwi_pkg::rwi_apb_req_type apb_req,
  output rwi_pkg::rwi_apb_rsp_type    apb_rsp,
  input  wire rwi_pkg::rwi_osc_type   osc_mode,
  input  wire logic                   bor_evt,
  input  wire logic                   master_clear_reset_evt,
  input  wire logic                   wdt_rst_evt,
  input  wire logic                   reset_instr_evt,
  input  wire logic                   sleep_req,
  input  wire logic                   wdt_wake,
  input  wire logic [6:0]             irq_src,
  input  wire logic                   irq_high_req,
  input  wire logic [20:0]            pc_in,
  input  wire logic [7:0]             port_a_in,
  output logic [7:0]                  port_a_out,
  output logic [7:0]                  port_a_oe,
  output logic                        cpu_run,
  output logic                        pc_load,
  output logic [20:0]                 pc_vector,
  output logic                        tos_write,
  output logic [20:0]                 tos_value,
  output logic [4:0]                  stack_pointer,
  output logic                        long_write_enable,
  output logic                        soft_watchdog_enable,
  output logic                        irq
);
  import rwi_pkg::*;

  rwi_state_type state_reg;
  logic [7:0]    wdt_ctrl_reg;
  logic [7:0]    rcs_reg;
  logic [7:0]    gie_reg;
  logic [7:0]    evt_reg;
  logic [7:0]    msk_reg;
  logic [7:0]    lat_reg;
  logic [7:0]    dir_reg;
  logic [7:0]    pin_s1_reg;
  logic [7:0]    pin_s2_reg;
  logic          wake_irq_reg;
  logic          timer_done;
  logic          io_mode;
  logic [7:0]    bit6_mask;
  logic          acc;
  logic          fin;
  logic          wr;
  logic          hit;
  logic [7:0]    rdata;
  logic [7:0]    wdat;
  logic          wake_now;
  logic          any_rst;
  logic          gie_any;

  assign io_mode   = (osc_mode == OSC_RC_OSC_WITH_IO_MODE) || (osc_mode == OSC_EXT_CLOCK_WITH_IO_MODE);
  assign bit6_mask = io_mode ? 8'hff : ~(8'h01 << PA_BIT6);
  assign acc       = apb_req.psel && apb_req.penable;
  assign fin       = acc && apb_rsp.pready;
  assign wr        = fin && apb_req.pwrite && hit;
  assign wdat      = apb_req.pwdata[7:0];
  assign wake_now  = (state_reg == ST_SLEEP) && (wdt_wake || (|irq_src));
  assign any_rst   = bor_evt || master_clear_reset_evt || wdt_rst_evt || reset_instr_evt;
  assign gie_any   = gie_reg[GIE_HIGH] || gie_reg[GIE_LOW];

  rwi_wake_timer #(
    .PLL_CYC (PLL_CYC)
  ) u_timer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .start    (wake_now),
    .osc_mode (osc_mode),
    .done     (timer_done)
  );

  // register read mux; undecoded bits stay zero
  always_comb begin
    hit   = 1'b1;
    rdata = 8'h00;
    case (apb_req.paddr)
      OFS_WDT: rdata = wdt_ctrl_reg & WDT_IMPL;
      OFS_RCS: rdata = rcs_reg;
      OFS_GIE: rdata = gie_reg & GIE_IMPL;
      OFS_EVT: rdata = evt_reg;
      OFS_MSK: rdata = msk_reg;
      OFS_LAT: rdata = lat_reg & PA_IMPL & bit6_mask;
      OFS_DIR: rdata = dir_reg & PA_IMPL & bit6_mask;
      OFS_PIN: rdata = pin_s2_reg & PA_IMPL & bit6_mask;
      OFS_STK: rdata = {3'h0, stack_pointer};
      default: hit = 1'b0;
    endcase
  end

  // one wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      apb_rsp <= '0;
    end else if (acc && !apb_rsp.pready) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.prdata  <= {24'h000000, rdata};
      apb_rsp.pslverr <= !hit;
    end else begin
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    pin_s1_reg <= port_a_in;
    pin_s2_reg <= pin_s1_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || bor_evt) begin
      wdt_ctrl_reg <= WDT_RESET;
    end else if (wr && apb_req.paddr == OFS_WDT) begin
      wdt_ctrl_reg <= wdat & WDT_IMPL;
    end
  end

  // reset cause status: hardware events are applied after software writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rcs_reg <= RCS_POR_VAL;
    end else begin
      if (wr && apb_req.paddr == OFS_RCS) begin
        rcs_reg <= (rcs_reg & ~RCS_WMASK) | (wdat & RCS_WMASK);
      end
      if (bor_evt) begin
        rcs_reg[RCS_PRIORITY_LEVEL_ENABLE] <= 1'b0;
        rcs_reg[RCS_RI]   <= 1'b1;
        rcs_reg[RCS_TO]   <= 1'b1;
        rcs_reg[RCS_PD]   <= 1'b1;
        rcs_reg[RCS_BOR]  <= 1'b0;
      end
      if (master_clear_reset_evt) begin
        rcs_reg[RCS_LONG_WRITE_ENABLE] <= 1'b0;
      end
      if (wdt_rst_evt) begin
        rcs_reg[RCS_TO] <= 1'b0;
      end
      if (reset_instr_evt) begin
        rcs_reg[RCS_RI] <= 1'b0;
      end
      if (state_reg == ST_RUN && sleep_req && !any_rst) begin
        rcs_reg[RCS_TO] <= 1'b1;
        rcs_reg[RCS_PD] <= 1'b0;
      end
      if (wake_now && wdt_wake) begin
        rcs_reg[RCS_TO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || any_rst) begin
      gie_reg <= 8'h00;
    end else if (wr && apb_req.paddr == OFS_GIE) begin
      gie_reg <= wdat & GIE_IMPL;
    end
  end

  // wake flags; a read clears only the bits it returned, new ones win
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      evt_reg <= 8'h00;
    end else begin
      if (fin && !apb_req.pwrite && apb_req.paddr == OFS_EVT) begin
        evt_reg <= (evt_reg & ~apb_rsp.prdata[7:0]) | ({1'b0, irq_src} & {8{wake_now}})
                   | ({wdt_wake, 7'h00} & {8{wake_now}});
      end else if (wake_now) begin
        evt_reg <= evt_reg | {wdt_wake, irq_src};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      msk_reg <= 8'h00;
    end else if (wr && apb_req.paddr == OFS_MSK) begin
      msk_reg <= wdat;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lat_reg <= LAT_RESET;
      dir_reg <= DIR_RESET;
    end else begin
      if (wr && apb_req.paddr == OFS_LAT) begin
        lat_reg <= wdat & PA_IMPL & bit6_mask;
      end
      if (master_clear_reset_evt || bor_evt) begin
        dir_reg <= DIR_RESET & bit6_mask;
      end else if (wr && apb_req.paddr == OFS_DIR) begin
        dir_reg <= wdat & PA_IMPL & bit6_mask;
      end
    end
  end

  // pins: direction bit 1 means input
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_a_out <= 8'h00;
      port_a_oe  <= 8'h00;
    end else begin
      port_a_out <= lat_reg & PA_IMPL & bit6_mask;
      port_a_oe  <= ~dir_reg & PA_IMPL & bit6_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      long_write_enable    <= 1'b0;
      soft_watchdog_enable <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      long_write_enable    <= rcs_reg[RCS_LONG_WRITE_ENABLE];
      soft_watchdog_enable <= wdt_ctrl_reg[0];
      irq                  <= |(evt_reg & msk_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || any_rst) begin
      state_reg    <= ST_RUN;
      wake_irq_reg <= 1'b0;
      cpu_run      <= 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (sleep_req) begin
            state_reg <= ST_SLEEP;
            cpu_run   <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (wake_now) begin
            state_reg    <= ST_WAKE;
            wake_irq_reg <= |irq_src;
          end
        end
        ST_WAKE: begin
          if (timer_done) begin
            if (wake_irq_reg && gie_any) begin
              state_reg <= ST_VECT;
            end else begin
              state_reg <= ST_RUN;
              cpu_run   <= 1'b1;
            end
          end
        end
        ST_VECT: begin
          state_reg <= ST_RUN;
          cpu_run   <= 1'b1;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // vector load and stack push happen together, one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pc_load       <= 1'b0;
      pc_vector     <= 21'h000000;
      tos_write     <= 1'b0;
      tos_value     <= 21'h000000;
      stack_pointer <= 5'h00;
    end else if (state_reg == ST_VECT && !any_rst) begin
      pc_load       <= 1'b1;
      pc_vector     <= (irq_high_req && gie_reg[GIE_HIGH]) ? VEC_HIGH : VEC_LOW;
      tos_write     <= 1'b1;
      tos_value     <= pc_in;
      stack_pointer <= stack_pointer + 5'h01;
    end else begin
      pc_load       <= 1'b0;
      tos_write     <= 1'b0;
    end
  end

  logic [CNT_W-1:0] wake_cyc;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_reg != ST_WAKE) begin
      wake_cyc <= '0;
    end else begin
      wake_cyc <= wake_cyc + CNT_W'(1);
    end
  end

  sequence s_fast_start;
    wake_now && !any_rst && (osc_mode inside {OSC_RC, OSC_RC_OSC_WITH_IO_MODE, OSC_EC, OSC_EXT_CLOCK_WITH_IO_MODE});
  endsequence

  sequence s_fast_wait;
    !timer_done [*8] ##1 timer_done;
  endsequence

  property p_fast_resume;
    @(posedge sys_clk) disable iff (sys_rst) s_fast_start |=> s_fast_wait;
  endproperty
  a_fast_resume: assert property (p_fast_resume) else $error("fast wake not 8 cycles");

  property p_pll_wait;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_reg == ST_WAKE && timer_done && osc_mode == OSC_HSPLL)
      |-> wake_cyc == CNT_W'(OST_CYC + PLL_CYC);
  endproperty
  a_pll_wait: assert property (p_pll_wait) else $error("pll wake wait wrong");

  property p_vector;
    @(posedge sys_clk) disable iff (sys_rst || any_rst)
      state_reg == ST_VECT |=> pc_load && pc_vector ==
        (($past(irq_high_req) && $past(gie_reg[GIE_HIGH])) ? VEC_HIGH : VEC_LOW);
  endproperty
  a_vector: assert property (p_vector) else $error("vector load wrong");

  property p_push;
    @(posedge sys_clk) disable iff (sys_rst)
      pc_load |-> tos_write && tos_value == $past(pc_in)
                  && stack_pointer == $past(stack_pointer) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");

  property p_long_write_enable_keep;
    @(posedge sys_clk) disable iff (sys_rst)
      (wdt_rst_evt || reset_instr_evt || bor_evt) && !master_clear_reset_evt && !wr
      |=> rcs_reg[RCS_LONG_WRITE_ENABLE] == $past(rcs_reg[RCS_LONG_WRITE_ENABLE]);
  endproperty
  a_long_write_enable_keep: assert property (p_long_write_enable_keep) else $error("long write changed");

  property p_bit6_off;
    @(posedge sys_clk) disable iff (sys_rst)
      !io_mode [*2] |-> !port_a_oe[PA_BIT6] && !port_a_out[PA_BIT6];
  endproperty
  a_bit6_off: assert property (p_bit6_off) else $error("port bit six active");

  property p_wake_flags;
    @(posedge sys_clk) disable iff (sys_rst)
      wake_now |=> (evt_reg & {$past(wdt_wake), $past(irq_src)})
                   == {$past(wdt_wake), $past(irq_src)};
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("wake flags not set");

  property p_por_pattern;
    @(posedge sys_clk) disable iff (sys_rst) $fell(sys_rst) |-> rcs_reg == RCS_POR_VAL;
  endproperty
  a_por_pattern: assert property (p_por_pattern) else $error("status pattern wrong");

  property p_zero_upper;
    @(posedge sys_clk) disable iff (sys_rst)
      apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000
        && ($past(apb_req.paddr) != OFS_WDT || apb_rsp.prdata[7:1] == 7'h00);
  endproperty
  a_zero_upper: assert property (p_zero_upper) else $error("unimplemented bits set");

endmodule

// [testbench/rwi_top_test.sv]
`timescale 1ns/1ps
module rwi_top_test;
  import rwi_pkg::*;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    logic        err;
  } rwi_note_type;
  localparam int unsigned PLL = 16;
  logic            sys_clk, sys_rst, bor_evt, master_clear_reset_evt, wdt_rst_evt, reset_instr_evt;
  logic            sleep_req, wdt_wake, irq_high_req, cpu_run, pc_load, tos_write;
  logic            long_write_enable, soft_watchdog_enable, irq;
  rwi_apb_req_type apb_req;
  rwi_apb_rsp_type apb_rsp;
  rwi_osc_type     osc_mode;
  logic [6:0]      irq_src;
  logic [20:0]     pc_in, pc_vector, tos_value;
  logic [7:0]      port_a_in, port_a_out, port_a_oe, pins, im;
  logic [4:0]      stack_pointer;
  int              error_cnt, n_compared;
  rwi_note_type    notes[$];

  rwi_top #(.PLL_CYC(PLL)) i_rwi_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .osc_mode(osc_mode), .bor_evt(bor_evt), .master_clear_reset_evt(master_clear_reset_evt),
    .wdt_rst_evt(wdt_rst_evt), .reset_instr_evt(reset_instr_evt), .sleep_req(sleep_req),
    .wdt_wake(wdt_wake), .irq_src(irq_src), .irq_high_req(irq_high_req), .pc_in(pc_in),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe), .cpu_run(cpu_run),
    .pc_load(pc_load), .pc_vector(pc_vector), .tos_write(tos_write), .tos_value(tos_value),
    .stack_pointer(stack_pointer), .long_write_enable(long_write_enable),
    .soft_watchdog_enable(soft_watchdog_enable), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // reads leave a note; the monitor below checks it when pready comes
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    if (!wr)
      notes.push_back('{e, m, (a > OFS_STK)});
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // no cycle count is assumed here; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (!apb_rsp.pready);
    apb_req <= '{1'b0, 1'b0, wr, a, d};
  endtask

  always @(posedge sys_clk) begin
    rwi_note_type nt;
    if (apb_rsp.pready && apb_req.psel && !apb_req.pwrite && notes.size() > 0) begin
      nt = notes.pop_front();
      chk(apb_rsp.prdata & nt.m, nt.e & nt.m);
      chk({31'h0, apb_rsp.pslverr}, {31'h0, nt.err});
    end
  end

  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: bor_evt <= 1'b1;
      1: master_clear_reset_evt <= 1'b1;
      2: wdt_rst_evt <= 1'b1;
      default: reset_instr_evt <= 1'b1;
    endcase
    @(posedge sys_clk);
    {bor_evt, master_clear_reset_evt, wdt_rst_evt, reset_instr_evt} <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  // sleep, wake by irq or watchdog, count cycles until the core runs again
  task automatic wake(input rwi_osc_type md, input logic [6:0] src, input logic wd,
                      input logic [7:0] gie, input logic hi, input logic [7:0] msk,
                      input int exn, input logic [20:0] vec);
    int n;
    logic seen;
    logic [4:0] sp0;
    logic [20:0] pc;
    apb(1'b1, OFS_GIE, {24'h0, gie}, 0, 0);
    apb(1'b1, OFS_MSK, {24'h0, msk}, 0, 0);
    pc = 21'($urandom);
    sp0 = stack_pointer;
    osc_mode <= md;
    irq_high_req <= hi;
    pc_in <= pc;
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    irq_src <= src;
    wdt_wake <= wd;
    @(posedge sys_clk);
    irq_src <= 7'h00;
    wdt_wake <= 1'b0;
    n = 0;
    seen = 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      if (pc_load) begin
        seen = 1'b1;
        chk({11'h0, pc_vector}, {11'h0, vec});
        chk({11'h0, tos_value}, {11'h0, pc});
        chk({31'h0, tos_write}, 32'h1);
        chk({27'h0, stack_pointer}, {27'h0, sp0 + 5'd1});
      end
    end while (!cpu_run && n < 3000);
    chk(32'(n), 32'(exn));
    chk({31'h0, seen}, {31'h0, vec != 21'h0});
    chk({31'h0, irq}, {31'h0, |({wd, src} & msk)});
    apb(1'b0, OFS_EVT, 0, {24'h0, wd, src}, 32'hffffffff);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  initial begin
    #(50 * 30000);
    error_cnt++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    apb_req = '{1'b0, 1'b0, 1'b0, 8'h00, 32'h0};
    osc_mode = OSC_HS;
    {bor_evt, master_clear_reset_evt, wdt_rst_evt, reset_instr_evt} = 4'h0;
    {sleep_req, wdt_wake, irq_high_req} = 3'h0;
    irq_src = 7'h00;
    pc_in = 21'($urandom(32'h0da6));
    port_a_in = 8'h00;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_RCS, 0, {24'h0, RCS_POR_VAL}, 32'hffffffff);
    apb(1'b0, OFS_DIR, 0, 32'h3f, 32'hffffffff);
    apb(1'b0, 8'h30, 0, 0, 32'hffffffff);
    apb(1'b1, OFS_WDT, 32'hffffffff, 0, 0);
    apb(1'b0, OFS_WDT, 0, 32'h01, 32'hffffffff);
    chk({31'h0, soft_watchdog_enable}, 32'h1);
    apb(1'b1, OFS_RCS, 32'hff, 0, 0);
    apb(1'b0, OFS_RCS, 0, 32'hdf, 32'hffffffff);
    for (int k = 3; k >= 1; k--) begin
      pulse(k);
      apb(1'b0, OFS_RCS, 0, (k == 1) ? 32'h0 : 32'h40, 32'h40);
      chk({31'h0, long_write_enable}, {31'h0, k != 1});
    end
    apb(1'b1, OFS_RCS, 32'hff, 0, 0);
    pulse(0);
    apb(1'b0, OFS_RCS, 0, 32'h5e, 32'hffffffff);
    apb(1'b0, OFS_WDT, 0, 32'h0, 32'hffffffff);
    for (int k = 0; k < 2; k++) begin
      im = k ? 8'h7f : 8'h3f;
      pins = 8'($urandom);
      osc_mode <= k ? OSC_EXT_CLOCK_WITH_IO_MODE : OSC_HS;
      port_a_in <= pins;
      apb(1'b1, OFS_LAT, 32'hff, 0, 0);
      apb(1'b1, OFS_DIR, 32'h0, 0, 0);
      apb(1'b0, OFS_LAT, 0, {24'h0, im}, 32'hffffffff);
      apb(1'b0, OFS_PIN, 0, {24'h0, pins & im}, 32'hffffffff);
      chk({24'h0, port_a_out}, {24'h0, im});
      chk({24'h0, port_a_oe}, {24'h0, im});
      apb(1'b1, OFS_DIR, 32'hff, 0, 0);
      apb(1'b0, OFS_DIR, 0, {24'h0, im}, 32'hffffffff);
      chk({24'h0, port_a_oe}, 32'h0);
    end
    wake(OSC_EC, 7'($urandom) | 7'h01, 1'b0, 8'h80, 1'b1, 8'hff, FAST_CYC + 2, VEC_HIGH);
    wake(OSC_RC_OSC_WITH_IO_MODE, 7'($urandom) | 7'h02, 1'b0, 8'h40, 1'b0, 8'h7f, FAST_CYC + 2, VEC_LOW);
    wake(OSC_EXT_CLOCK_WITH_IO_MODE, 7'($urandom) | 7'h04, 1'b0, 8'h40, 1'b1, 8'hff, FAST_CYC + 2, VEC_LOW);
    wake(OSC_RC, 7'h00, 1'b1, 8'h00, 1'b0, 8'h80, FAST_CYC + 1, 21'h0);
    wake(OSC_HSPLL, 7'h00, 1'b1, 8'hc0, 1'b1, 8'hff, OST_CYC + PLL + 1, 21'h0);
    wake(OSC_XT, 7'h10, 1'b0, 8'h00, 1'b1, 8'h00, OST_CYC + 1, 21'h0);
    // three vectored wakes so far; a second reset must restore the power-on state
    apb(1'b0, OFS_STK, 0, 32'h3, 32'hffffffff);
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_RCS, 0, {24'h0, RCS_POR_VAL}, 32'hffffffff);
    apb(1'b0, OFS_STK, 0, 32'h0, 32'hffffffff);
    chk({31'h0, cpu_run}, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(32'(notes.size()), 32'h0);
    summarize();
  end
endmodule
